// ### common/ema_consts.vh
`ifndef EMA_CONSTS_VH
`define EMA_CONSTS_VH

// ---------------------------------------------------------------
// Frame geometry
// ---------------------------------------------------------------
`define EMA_FRAME_LAST 12'd2559
`define EMA_SF_BITS    12'd640
`define EMA_SYNC_NEXT  12'd576
`define EMA_PAD_PHASE  4'hf
`define EMA_ENV_LAST   4'd9

// ---------------------------------------------------------------
// Padding bit numbers within a subframe, counted from zero
// ---------------------------------------------------------------
`define EMA_P_ALARM    6'd0
`define EMA_P_CHK_LO   6'd4
`define EMA_P_CHK_HI   6'd7
`define EMA_P_NAT_HI   6'd19
`define EMA_P_PAT_HI   6'd33
`define EMA_P_SFID_HI  6'd35
`define EMA_P_JSS_HI   6'd38

// ---------------------------------------------------------------
// Patterns and codes
// ---------------------------------------------------------------
`define EMA_PAT        14'h3e6a
`define EMA_CRC_POLY   16'h1021
`define EMA_JSS_NONE   3'h2
`define EMA_JSS_ADD    3'h4
`define EMA_JSS_DEL    3'h1
`define EMA_JUST_NONE  2'h0
`define EMA_JUST_ADD   2'h1
`define EMA_JUST_DEL   2'h2
`define EMA_LOF_ERRS   2'd3
`define EMA_VOTE_MAJ   3'd3

// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define EMA_A_CTRL     8'h00
`define EMA_A_NAT_TX   8'h04
`define EMA_A_STATUS   8'h08
`define EMA_A_CRC_ERRS 8'h0c
`define EMA_A_LOF_CNT  8'h10
`define EMA_A_NAT_RX   8'h14
`define EMA_C_CRC      0
`define EMA_C_JSS      1
`define EMA_C_SINGLE   2
`define EMA_CTRL_RST   3'h0
`define EMA_NAT_RST    12'hfff

`endif

// ### rtl/ema_frame_aligner.v
// How it works
// (RULE_01) Alignment word: fixed 14 bits plus subframe number
// (RULE_02) Three bad alignment words in row: lost
// (RULE_03) First bad word after regaining: lost again
// (RULE_04) Hunting ends on one valid pattern
// (RULE_05) Out of frame: outgoing envelopes all ones
// (RULE_06) Out of frame: alarm distant end, start hunt
// (RULE_07) Next two padding bits load position counters
// (RULE_08) Regained: stop forcing ones and alarm
// (RULE_09) Subframe: 640 bits, 40 numbered padding bits
// (RULE_10) Padding 1-4 housekeeping, 5-8 check, 9-20 national
// (RULE_11) Padding 21-34 pattern, 35-36 number, 37-40 housekeeping
// (RULE_12) Service signals follow each subframe number
// (RULE_13) Codes 010 none, 100 added, 001 deleted
// (RULE_14) Majority of four votes, else no justification
// (RULE_15) No justification assumed while out of frame
// (RULE_16) Only last subframe's justification bit counts
// (RULE_17) Remote alarm bit zero on alarm, else one
// (RULE_18) Reserved housekeeping bits B to H sent one
// (RULE_19) Check remainder over frame, sent next frame
// (RULE_20) Receiver compares remainder; blocked out of frame
// (RULE_21) Unused national bits sent as one
// (RULE_22) Optional single channel at 48k user rate
// (RULE_23) One padding bit after every 15 bits
// (RULE_24) Four equal subframes, equal alignment spacing
// (RULE_25) Envelope: status, alignment bit, eight data bits
// (RULE_26) Parallel hunt tests every offset together
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ns
`default_nettype none

`include "ema_consts.vh"

module ema_frame_aligner (
   // Clock and reset
   input  wire        clk,
   input  wire        rst,
   // APB slave
   input  wire [7:0]  paddr,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Transmit side
   input  wire        tx_tick,
   input  wire        tx_data_bit,
   input  wire        los_in,
   output reg         tx_data_take,
   output reg         line_tx_bit,
   output reg         line_tx_valid,
   // Receive side
   input  wire        rx_tick,
   input  wire        line_rx_bit,
   output reg         rx_data_bit,
   output reg         rx_data_valid,
   output reg         rx_env_start,
   output reg         in_frame,
   output reg         single_channel
);

   // ---------------------------------------------------------------
   // Constants and helpers
   // ---------------------------------------------------------------
   localparam [13:0] PAT      = `EMA_PAT;
   localparam [2:0]  JSS_NONE = `EMA_JSS_NONE;
   localparam [1:0]  ST_HUNT  = 2'd0;
   localparam [1:0]  ST_FIRST = 2'd1;
   localparam [1:0]  ST_SYNC  = 2'd2;

   function [11:0] sf_base;
      input [1:0] s;
      begin
         sf_base = {10'd0, s} * `EMA_SF_BITS; // RULE_24
      end
   endfunction

   function [1:0] sub_of;
      input [11:0] p;
      begin
         if (p < sf_base(2'd1))
            sub_of = 2'd0;
         else if (p < sf_base(2'd2))
            sub_of = 2'd1;
         else if (p < sf_base(2'd3))
            sub_of = 2'd2;
         else
            sub_of = 2'd3;
      end
   endfunction

   function [5:0] pad_num;
      input [11:0] p;
      reg   [11:0] off;
      begin
         off     = p - sf_base(sub_of(p));
         pad_num = off[9:4]; // RULE_09
      end
   endfunction

   function [15:0] crc_step;
      input [15:0] c;
      input        b;
      begin
         crc_step = {c[14:0], 1'b0} ^ ((b ^ c[15]) ? `EMA_CRC_POLY : 16'h0000);
      end
   endfunction

   // ---------------------------------------------------------------
   // Registers seen by software
   // ---------------------------------------------------------------
   reg  [2:0]  ctrl_reg;
   reg  [11:0] nat_tx_reg;
   reg  [11:0] nat_rx_reg;
   reg  [15:0] crc_errs_reg;
   reg  [15:0] lof_cnt_reg;
   reg  [1:0]  state_reg;
   reg  [1:0]  rx_just_reg;
   reg         far_alarm_reg;
   wire        oof = (state_reg == ST_HUNT);

   // ---------------------------------------------------------------
   // Transmitter
   // ---------------------------------------------------------------
   reg  [11:0] tx_pos_reg;
   reg  [15:0] tx_crc_reg;
   reg  [15:0] tx_chk_reg;
   reg         tx_pbit;
   wire        tx_pad = (tx_pos_reg[3:0] == `EMA_PAD_PHASE); // RULE_23
   wire [5:0]  tx_pn  = pad_num(tx_pos_reg);
   wire [1:0]  tx_sf  = sub_of(tx_pos_reg);
   wire [5:0]  tx_ni  = `EMA_P_NAT_HI - tx_pn;
   wire [5:0]  tx_qi  = `EMA_P_PAT_HI - tx_pn;
   wire [5:0]  tx_ji  = `EMA_P_JSS_HI - tx_pn;
   wire        tx_bit = tx_pad ? tx_pbit : tx_data_bit;

   always @* begin
      tx_pbit = 1'b1; // RULE_18
      if (tx_pn == `EMA_P_ALARM)
         tx_pbit = ~(oof | los_in); // RULE_17 RULE_06 RULE_08
      else if (tx_pn >= `EMA_P_CHK_LO && tx_pn <= `EMA_P_CHK_HI)
         tx_pbit = ~ctrl_reg[`EMA_C_CRC] | tx_chk_reg[{~tx_sf, ~tx_pn[1:0]}]; // RULE_19 RULE_10
      else if (tx_pn > `EMA_P_CHK_HI && tx_pn <= `EMA_P_NAT_HI)
         tx_pbit = nat_tx_reg[tx_ni[3:0]]; // RULE_21 RULE_10
      else if (tx_pn > `EMA_P_NAT_HI && tx_pn <= `EMA_P_PAT_HI)
         tx_pbit = PAT[tx_qi[3:0]]; // RULE_01 RULE_11
      else if (tx_pn > `EMA_P_PAT_HI && tx_pn <= `EMA_P_SFID_HI)
         tx_pbit = tx_sf[~tx_pn[0]]; // RULE_01
      else if (tx_pn > `EMA_P_SFID_HI && tx_pn <= `EMA_P_JSS_HI)
         tx_pbit = ~ctrl_reg[`EMA_C_JSS] | JSS_NONE[tx_ji[1:0]]; // RULE_12 RULE_13
   end

   // Locked bearer: always one trailing padding bit, never justified
   always @(posedge clk) begin
      if (rst) begin
         tx_pos_reg    <= 12'd0;
         tx_crc_reg    <= 16'h0000;
         tx_chk_reg    <= 16'hffff;
         tx_data_take  <= 1'b0;
         line_tx_bit   <= 1'b1;
         line_tx_valid <= 1'b0;
      end else begin
         tx_data_take  <= 1'b0;
         line_tx_valid <= 1'b0;
         if (tx_tick) begin
            line_tx_bit   <= tx_bit;
            line_tx_valid <= 1'b1;
            tx_data_take  <= ~tx_pad;
            if (tx_pos_reg == `EMA_FRAME_LAST) begin
               tx_pos_reg <= 12'd0;
               tx_chk_reg <= crc_step(tx_crc_reg, tx_bit); // RULE_19
               tx_crc_reg <= 16'h0000;
            end else begin
               tx_pos_reg <= tx_pos_reg + 12'd1;
               tx_crc_reg <= crc_step(tx_crc_reg, tx_bit);
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Receiver position and checks
   // ---------------------------------------------------------------
   reg  [11:0] rx_pos_reg;
   reg  [15:0] rx_sr_reg;
   reg  [1:0]  errs_reg;
   reg  [2:0]  v_none_reg;
   reg  [2:0]  v_add_reg;
   reg  [2:0]  v_del_reg;
   reg  [15:0] rx_crc_reg;
   reg  [15:0] rx_hold_reg;
   reg  [15:0] rx_chk_reg;
   reg  [11:0] rx_nat_sr_reg;
   reg  [3:0]  env_reg;
   reg         run_v_reg;
   reg         prev_v_reg;
   reg  [1:0]  just_dec;
   wire        hunt_found;
   wire [1:0]  hunt_sf;
   wire        rx_pad  = (rx_pos_reg[3:0] == `EMA_PAD_PHASE); // RULE_23
   wire [5:0]  rx_pn   = pad_num(rx_pos_reg);
   wire [1:0]  rx_sf   = sub_of(rx_pos_reg);
   wire [15:0] rx_win  = {rx_sr_reg[14:0], line_rx_bit};
   wire        sync_ok = (rx_win == {PAT, rx_sf}); // RULE_01
   wire [15:0] rx_crc_next = crc_step(rx_crc_reg, line_rx_bit);
   wire        chk_pt  = rx_tick & ~oof & rx_pad & (rx_pn == `EMA_P_SFID_HI);
   wire        lof_inc = chk_pt & ~sync_ok &
                         ((state_reg == ST_FIRST) | (errs_reg == `EMA_LOF_ERRS - 2'd1)); // RULE_02 RULE_03
   wire        crc_inc = rx_tick & ~oof & (rx_pos_reg == `EMA_FRAME_LAST) & prev_v_reg &
                         ctrl_reg[`EMA_C_CRC] & (rx_chk_reg != rx_hold_reg); // RULE_20
   wire [2:0]  code    = rx_win[2:0];
   wire [2:0]  nv_none = v_none_reg + {2'b00, code == `EMA_JSS_NONE};
   wire [2:0]  nv_add  = v_add_reg + {2'b00, code == `EMA_JSS_ADD};
   wire [2:0]  nv_del  = v_del_reg + {2'b00, code == `EMA_JSS_DEL};

   always @* begin
      just_dec = `EMA_JUST_NONE; // RULE_14
      if (nv_add >= `EMA_VOTE_MAJ)
         just_dec = `EMA_JUST_ADD;
      else if (nv_del >= `EMA_VOTE_MAJ)
         just_dec = `EMA_JUST_DEL;
   end

   ema_hunter u_hunter (
      .clk      (clk),
      .rst      (rst),
      .hunting  (oof),
      .tick     (rx_tick),
      .bit_in   (line_rx_bit),
      .found    (hunt_found),
      .found_sf (hunt_sf)
   );

   always @(posedge clk) begin
      if (rst) begin
         state_reg     <= ST_HUNT;
         rx_pos_reg    <= 12'd0;
         rx_sr_reg     <= 16'h0000;
         errs_reg      <= 2'd0;
         v_none_reg    <= 3'd0;
         v_add_reg     <= 3'd0;
         v_del_reg     <= 3'd0;
         rx_just_reg   <= `EMA_JUST_NONE;
         rx_crc_reg    <= 16'h0000;
         rx_hold_reg   <= 16'h0000;
         rx_chk_reg    <= 16'h0000;
         rx_nat_sr_reg <= 12'h000;
         nat_rx_reg    <= `EMA_NAT_RST;
         far_alarm_reg <= 1'b0;
         run_v_reg     <= 1'b0;
         prev_v_reg    <= 1'b0;
         env_reg       <= 4'd0;
         rx_data_bit   <= 1'b1;
         rx_data_valid <= 1'b0;
         rx_env_start  <= 1'b0;
      end else begin
         rx_data_valid <= 1'b0;
         rx_env_start  <= 1'b0;
         if (rx_tick) begin
            rx_pos_reg <= (rx_pos_reg == `EMA_FRAME_LAST) ? 12'd0 : rx_pos_reg + 12'd1;
            if (rx_pad) begin
               rx_sr_reg <= rx_win;
            end else begin
               rx_data_bit   <= oof | line_rx_bit; // RULE_05 RULE_08
               rx_data_valid <= 1'b1;
               if (rx_pos_reg == 12'd0 || env_reg == 4'd0) begin
                  rx_env_start <= 1'b1; // RULE_25
                  env_reg      <= 4'd1;
               end else begin
                  env_reg <= (env_reg == `EMA_ENV_LAST) ? 4'd0 : env_reg + 4'd1;
               end
            end
            if (oof) begin
               rx_just_reg <= `EMA_JUST_NONE; // RULE_15
               run_v_reg   <= 1'b0;
               prev_v_reg  <= 1'b0;
               v_none_reg  <= 3'd0;
               v_add_reg   <= 3'd0;
               v_del_reg   <= 3'd0;
               if (hunt_found) begin
                  state_reg  <= ST_FIRST; // RULE_04
                  rx_pos_reg <= sf_base(hunt_sf) + `EMA_SYNC_NEXT; // RULE_07
                  errs_reg   <= 2'd0;
               end
            end else begin
               if (chk_pt) begin
                  if (sync_ok) begin
                     state_reg <= ST_SYNC;
                     errs_reg  <= 2'd0;
                  end else if (lof_inc) begin
                     state_reg <= ST_HUNT; // RULE_02 RULE_03 RULE_06
                  end else begin
                     errs_reg <= errs_reg + 2'd1;
                  end
               end
               if (rx_pad && rx_pn == `EMA_P_ALARM)
                  far_alarm_reg <= ~line_rx_bit;
               if (rx_pad && rx_pn >= `EMA_P_CHK_LO && rx_pn <= `EMA_P_CHK_HI)
                  rx_chk_reg <= {rx_chk_reg[14:0], line_rx_bit};
               if (rx_pad && rx_pn > `EMA_P_CHK_HI && rx_pn <= `EMA_P_NAT_HI)
                  rx_nat_sr_reg <= {rx_nat_sr_reg[10:0], line_rx_bit};
               if (rx_pad && rx_pn == `EMA_P_NAT_HI)
                  nat_rx_reg <= {rx_nat_sr_reg[10:0], line_rx_bit};
               if (rx_pad && rx_pn == `EMA_P_JSS_HI) begin
                  if (rx_sf == 2'd3) begin
                     rx_just_reg <= just_dec; // RULE_14 RULE_16
                     v_none_reg  <= 3'd0;
                     v_add_reg   <= 3'd0;
                     v_del_reg   <= 3'd0;
                  end else begin
                     v_none_reg <= nv_none; // RULE_12
                     v_add_reg  <= nv_add;
                     v_del_reg  <= nv_del;
                  end
               end
               if (rx_pos_reg == `EMA_FRAME_LAST) begin
                  rx_crc_reg <= 16'h0000;
                  run_v_reg  <= 1'b1;
                  if (run_v_reg) begin
                     rx_hold_reg <= rx_crc_next; // RULE_20
                     prev_v_reg  <= 1'b1;
                  end
               end else begin
                  rx_crc_reg <= rx_crc_next;
               end
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // APB slave, one wait-free access phase
   // ---------------------------------------------------------------
   reg  [31:0] rd_mux;
   reg         mapped;
   wire        setup  = psel & ~penable;
   wire        wr_acc = psel & penable & pready & pwrite;
   wire        clr_lof = wr_acc & (paddr == `EMA_A_LOF_CNT);
   wire        clr_crc = wr_acc & (paddr == `EMA_A_CRC_ERRS);

   always @* begin
      mapped = 1'b1;
      case (paddr)
         `EMA_A_CTRL:     rd_mux = {29'd0, ctrl_reg};
         `EMA_A_NAT_TX:   rd_mux = {20'd0, nat_tx_reg};
         `EMA_A_STATUS:   rd_mux = {28'd0, rx_just_reg, far_alarm_reg, ~oof};
         `EMA_A_CRC_ERRS: rd_mux = {16'd0, crc_errs_reg};
         `EMA_A_LOF_CNT:  rd_mux = {16'd0, lof_cnt_reg};
         `EMA_A_NAT_RX:   rd_mux = {20'd0, nat_rx_reg};
         default: begin
            rd_mux = 32'h0000_0000;
            mapped = 1'b0;
         end
      endcase
   end

   // Counters: an event in the clearing cycle still counts
   always @(posedge clk) begin
      if (rst) begin
         pready         <= 1'b0;
         pslverr        <= 1'b0;
         prdata         <= 32'h0000_0000;
         ctrl_reg       <= `EMA_CTRL_RST;
         nat_tx_reg     <= `EMA_NAT_RST;
         lof_cnt_reg    <= 16'h0000;
         crc_errs_reg   <= 16'h0000;
         in_frame       <= 1'b0;
         single_channel <= 1'b0;
      end else begin
         pready  <= setup;
         pslverr <= setup & ~mapped;
         prdata  <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
         if (wr_acc && paddr == `EMA_A_CTRL)
            ctrl_reg <= pwdata[2:0];
         if (wr_acc && paddr == `EMA_A_NAT_TX)
            nat_tx_reg <= pwdata[11:0]; // RULE_21
         if (lof_inc)
            lof_cnt_reg <= clr_lof ? 16'h0001 : lof_cnt_reg + 16'h0001;
         else if (clr_lof)
            lof_cnt_reg <= 16'h0000;
         if (crc_inc)
            crc_errs_reg <= clr_crc ? 16'h0001 : crc_errs_reg + 16'h0001;
         else if (clr_crc)
            crc_errs_reg <= 16'h0000;
         in_frame <= ~oof;
         // Framing is identical; the flag only tells the user side
         single_channel <= ctrl_reg[`EMA_C_SINGLE]; // RULE_22
      end
   end

endmodule // ema_frame_aligner

`default_nettype wire

// ### rtl/ema_hunter.v
`timescale 1ns/1ns
`default_nettype none

`include "ema_consts.vh"

module ema_hunter (
   // Clock and reset
   input  wire       clk,
   input  wire       rst,
   // Incoming bearer
   input  wire       hunting,
   input  wire       tick,
   input  wire       bit_in,
   // Match
   output wire       found,
   output wire [1:0] found_sf
);

   localparam [13:0] PAT = `EMA_PAT;

   // One padding window per bit phase, so all offsets are tested together
   reg  [15:0] win_reg [0:15];
   reg  [3:0]  ph_reg;
   wire [15:0] win_next = {win_reg[ph_reg][14:0], bit_in};
   integer     i;

   assign found    = hunting & tick & (win_next[15:2] == PAT); // RULE_26 RULE_04
   assign found_sf = win_next[1:0];                           // RULE_07

   always @(posedge clk) begin
      if (rst) begin
         ph_reg <= 4'h0;
         for (i = 0; i < 16; i = i + 1) begin
            win_reg[i] <= 16'h0000;
         end
      end else if (tick) begin
         win_reg[ph_reg] <= win_next;
         ph_reg          <= ph_reg + 4'h1;
      end
   end

endmodule // ema_hunter

`default_nettype wire

// ### testbench/ema_far_end.sv
`timescale 1ns/1ns
`default_nettype none
module ema_far_end (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Faults and codes chosen by the bench
   input  wire logic [3:0]  bad_mask,
   input  wire logic [11:0] jss_codes,
   // Bearer towards the device
   output logic             tick,
   output logic             bit_out
);
   localparam logic [13:0] PAT = 14'h3e6a;
   logic [11:0] pos_reg;
   int          k;
   int          sf;
   logic        pad;
   // ------------------------------------
   // Padding content; check bits stay one, so they never match
   // ------------------------------------
   always_comb begin
      k = (pos_reg % 640) / 16;
      sf = pos_reg / 640;
      pad = 1'b1;
      if (k >= 20 && k <= 33)
         pad = PAT[33 - k] ^ (k == 20 && bad_mask[sf]);
      else if (k == 34 || k == 35)
         pad = sf[35 - k];
      else if (k >= 36 && k <= 38)
         pad = jss_codes[3 * sf + 38 - k];
   end
   // Line is valid only in the tick cycle; otherwise inverted
   always_ff @(posedge clk) begin
      if (rst) begin
         tick <= 1'b0;
         bit_out <= 1'b1;
         pos_reg <= 12'h0;
      end else if (!tick) begin
         tick <= 1'b1;
         bit_out <= (pos_reg[3:0] == 4'hf) ? pad : 1'b0;
         pos_reg <= (pos_reg == 12'h9ff) ? 12'h0 : pos_reg + 12'h1;
      end else begin
         tick <= 1'b0;
         bit_out <= ~bit_out;
      end
   end
endmodule // ema_far_end
`default_nettype wire

// ### testbench/ema_frame_aligner_assertions.sv
`timescale 1ns/1ns
`default_nettype none
`include "ema_consts.vh"
module ema_frame_aligner_assertions (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // Register bus
   input wire logic [7:0]  paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Bearer sides
   input wire logic        tx_data_take,
   input wire logic        line_tx_valid,
   input wire logic        rx_data_bit,
   input wire logic        rx_data_valid,
   input wire logic        rx_env_start,
   input wire logic        in_frame,
   input wire logic        single_channel
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic [4:0] run_reg;
   // ------------------------------------
   // Data bits sent since the last padding bit
   // ------------------------------------
   always_ff @(posedge clk)
      if (rst)
         run_reg <= 5'h0;
      else if (line_tx_valid)
         run_reg <= tx_data_take ? run_reg + 5'h1 : 5'h0;
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable && pready;
   endsequence
   AST_APB_ANSWER: assert property (s_setup |=> s_access)
      else $error("no answer one cycle after setup");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("pready held two cycles");
   AST_ERR_WITH_READY: assert property (pslverr |-> pready)
      else $error("pslverr outside access");
   AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
      else $error("read data not zero while idle");
   AST_SINGLE_CH: assert property ((s_access ##0 (pwrite && paddr == `EMA_A_CTRL))
      |=> ##1 single_channel == $past(pwdata[`EMA_C_SINGLE], 2))
      else $error("single channel not taken from control");
   AST_PAD_EVERY_16: assert property (line_tx_valid |-> tx_data_take == (run_reg != 5'hf))
      else $error("padding bit not after fifteen data bits");
   AST_OOF_ONES: assert property (rx_data_valid && !in_frame |-> rx_data_bit)
      else $error("data not forced to one out of frame");
   AST_ENV_START: assert property (rx_env_start |-> rx_data_valid)
      else $error("envelope start without data");
   AST_FRAME_HOLD: assert property ($rose(in_frame) |=> in_frame [*8])
      else $error("alignment dropped at once");
endmodule // ema_frame_aligner_assertions
`default_nettype wire

// ### testbench/ema_frame_aligner_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "ema_consts.vh"
`define EMA_CHK(got, exp) \
   begin \
      num_checks++; \
      if ((got) !== (exp)) begin \
         n_errors++; \
         $display("unexpected at %0t: got %0h want %0h", $time, got, exp); \
      end \
   end
module ema_frame_aligner_test;
   localparam int F = 5120;
   localparam logic [13:0] PAT = 14'h3e6a;
   logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        los_in = 1'b0, tx_data_bit = 1'b0, crc_on = 1'b0, err;
   logic [7:0]  paddr = 8'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, tick, lbit, tx_data_take, line_tx_bit, line_tx_valid;
   logic        rx_data_bit, rx_data_valid, rx_env_start, in_frame, single_channel;
   logic [3:0]  bad_mask = 4'h0;
   logic [11:0] jss = 12'h492;
   logic [39:0] pad_seen;
   logic [1:0]  e;
   int          n_errors, num_checks, cyc, tpos, n;
   ema_frame_aligner dut (
      .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_tick(tick),
      .tx_data_bit(tx_data_bit), .los_in(los_in), .tx_data_take(tx_data_take),
      .line_tx_bit(line_tx_bit), .line_tx_valid(line_tx_valid), .rx_tick(tick), .line_rx_bit(lbit),
      .rx_data_bit(rx_data_bit), .rx_data_valid(rx_data_valid), .rx_env_start(rx_env_start),
      .in_frame(in_frame), .single_channel(single_channel));
   ema_far_end fe (
      .clk(clk), .rst(rst), .bad_mask(bad_mask), .jss_codes(jss), .tick(tick), .bit_out(lbit));
   initial begin
      forever #5 clk = ~clk;
   end
   // ------------------------------------
   // Bus cycles, waits and line monitors
   // ------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_in(input logic v, input int lim);
      for (n = 0; n < lim && in_frame !== v; n++)
         @(posedge clk);
   endtask
   task automatic sync(input int p);
      do @(posedge clk); while (fe.pos_reg != 12'(p));
   endtask
   function automatic logic [1:0] exp_pad(input int k, input int sf);
      if (k == 0 || (crc_on && k >= 4 && k <= 7))
         return 2'b00;
      if (k >= 20 && k <= 33)
         return {1'b1, PAT[33 - k]};
      if (k == 34 || k == 35)
         return {1'b1, sf[35 - k]};
      return 2'b11;
   endfunction
   always @(posedge clk) begin
      if (rst)
         tpos <= 0;
      else if (line_tx_valid) begin
         tpos <= (tpos + 1) % 2560;
         if (tpos % 16 == 15) begin
            e = exp_pad((tpos % 640) / 16, tpos / 640);
            pad_seen[(tpos % 640) / 16] <= line_tx_bit;
            if (e[1]) `EMA_CHK(line_tx_bit, e[0])
         end else begin
            `EMA_CHK(line_tx_bit, tx_data_bit)
            tx_data_bit <= ~tx_data_bit;
         end
      end
      if (rx_data_valid) `EMA_CHK(rx_data_bit, ~in_frame)
   end
   // ------------------------------------
   // Scenarios
   // ------------------------------------
   task automatic t_regs;
      apb(0, `EMA_A_CTRL, 0);
      `EMA_CHK(rd, 32'h0)
      apb(0, `EMA_A_NAT_TX, 0);
      `EMA_CHK(rd, 32'hfff)
      apb(1, 8'h3c, 32'hffffffff);
      apb(0, 8'h3c, 0);
      `EMA_CHK({err, rd}, {1'b1, 32'h0})
      apb(1, `EMA_A_CTRL, 32'h4);
      repeat (2) @(posedge clk);
      `EMA_CHK(single_channel, 1'b1)
      apb(1, `EMA_A_CTRL, 0);
   endtask
   task automatic t_align;
      wait_in(1'b1, 2 * F);
      `EMA_CHK(in_frame, 1'b1)
      repeat (F) @(posedge clk);
      apb(0, `EMA_A_STATUS, 0);
      `EMA_CHK(rd[3:0], 4'h1)
      `EMA_CHK(pad_seen[0], 1'b1)
   endtask
   task automatic t_just;
      logic [11:0] codes [5] = '{12'h492, 12'h924, 12'h249, 12'h324, 12'h264};
      logic [1:0]  want [5] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h0};
      sync(2550);
      for (int i = 0; i < 5; i++) begin
         jss <= codes[i];
         repeat (F) @(posedge clk);
         apb(0, `EMA_A_STATUS, 0);
         `EMA_CHK(rd[3:2], want[i])
      end
   endtask
   task automatic t_los;
      los_in <= 1'b1;
      repeat (1400) @(posedge clk);
      `EMA_CHK(pad_seen[0], 1'b0)
      los_in <= 1'b0;
      repeat (1400) @(posedge clk);
      `EMA_CHK(pad_seen[0], 1'b1)
   endtask
   task automatic t_two_bad;
      jss <= 12'h924;
      sync(0);
      bad_mask <= 4'h3;
      repeat (F) @(posedge clk);
      bad_mask <= 4'h0;
      apb(0, `EMA_A_LOF_CNT, 0);
      `EMA_CHK({in_frame, rd}, {1'b1, 32'h0})
   endtask
   task automatic t_loss;
      sync(0);
      bad_mask <= 4'hf;
      wait_in(1'b0, 3 * 1280 + 400);
      `EMA_CHK(n > 3600 && n < 3800, 1'b1)
      crc_on <= 1'b1;
      apb(1, `EMA_A_CTRL, 32'h1);
      apb(1, `EMA_A_CRC_ERRS, 0);
      repeat (F) @(posedge clk);
      `EMA_CHK({in_frame, pad_seen[0]}, 2'b00)
      apb(0, `EMA_A_STATUS, 0);
      `EMA_CHK(rd[3:2], 2'h0)
      apb(0, `EMA_A_CRC_ERRS, 0);
      `EMA_CHK(rd, 32'h0)
      apb(0, `EMA_A_LOF_CNT, 0);
      `EMA_CHK(rd, 32'h1)
   endtask
   task automatic t_refail;
      bad_mask <= 4'he;
      wait_in(1'b1, F + 200);
      wait_in(1'b0, 1400);
      `EMA_CHK(n > 1270 && n < 1290, 1'b1)
      bad_mask <= 4'h0;
      wait_in(1'b1, F);
      apb(0, `EMA_A_LOF_CNT, 0);
      `EMA_CHK(rd, 32'h2)
   endtask
   task automatic t_crc;
      apb(1, `EMA_A_CRC_ERRS, 0);
      repeat (4 * F) @(posedge clk);
      apb(0, `EMA_A_CRC_ERRS, 0);
      `EMA_CHK(rd[15:0] != 16'h0, 1'b1)
      apb(0, `EMA_A_STATUS, 0);
      `EMA_CHK(rd[3:0], 4'h5)
   endtask
   task automatic finish_test;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 98000) begin
         n_errors++;
         $display("unexpected at %0t: timeout", $time);
         finish_test();
      end
   end
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_align();
      t_just();
      t_los();
      t_two_bad();
      t_loss();
      t_refail();
      t_crc();
      finish_test();
   end
endmodule // ema_frame_aligner_test
bind ema_frame_aligner ema_frame_aligner_assertions chk (
   .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .tx_data_take(tx_data_take), .line_tx_valid(line_tx_valid), .rx_data_bit(rx_data_bit),
   .rx_data_valid(rx_data_valid), .rx_env_start(rx_env_start), .in_frame(in_frame),
   .single_channel(single_channel));
`default_nettype wire
